// file: usb_endpoint0_control.sv
// Endpoint-zero control logic: handshakes, modes, STALL and registers over APB
// Operation
// - Handshakes are automatic; interrupt after complete packet received or sent-and-acked, and on STALL or setup end.
// - Corrupted or erroneous packets from the host raise no interrupt.
// - Interrupt on OUT/SETUP loaded, IN sent, IN status done, stall, setup end.
// - Receive count shows received bytes in low seven bits; top bit zero.
// - STALL on late OUT/IN after last data, oversize, nonempty status DATA1, send_stall.
// - Accept only eight-byte SETUP packets; reject any other length.
// - IN data interrupts on transmission; no interrupt for IN before packet loaded.
// - First IN enters transmit mode; SETUP or OUT there sets setup_end_flag.
// - Transmit mode ends on SETUP/OUT token, short packet or zero-length packet.
// - IN token answered with NAK while in_pkt_ready is zero.
// - Good OUT packet sets out_pkt_ready and interrupts; software then services it.
// - First OUT enters receive mode; SETUP or IN there sets setup_end_flag.
// - Receive mode ends on SETUP/IN token, short packet or zero-length packet.
// - setup_end_flag set on early transaction end; cleared by writing setup_end_serviced.
// - Writing out_serviced alone clears out_pkt_ready; it reads back zero.
// - send_stall aborts transfer; hardware clears it after STALL is sent.
// - last_data_done set by software with last packet; hardware clears it.
// - After any STALL, stall_sent is set with interrupt until software clears it.
// - in_pkt_ready cleared with interrupt on transmit or overwrite by SETUP/OUT.
//
// Added by the designer: the APB interface to the registers.
`include "ep0_defines.svh"
module usb_endpoint0_control
  import ep0_pkg::*;
#(
  parameter logic [6:0] MAX_PKT = `EP0_MAX_PKT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link engine events
  input wire link_ev_s ev,
  // Handshake to send and interrupt
  output hs_s hs,
  output logic ep0_irq
);

  state_s r_r;
  state_s r_nxt;
  logic pslverr_r;

  logic wr_csr;
  logic rd_acc;
  logic [7:0] wb;
  logic is_setup;
  logic is_out;
  logic is_in;
  logic rx_ok;
  logic short_rx;
  logic short_tx;
  logic fire_irq;

  assign rd_acc = psel && !penable;
  assign wr_csr = psel && penable && pwrite && pstrb[0] && (paddr == `EP0_CSR_ADDR);
  assign wb = pwdata[7:0];
  assign is_setup = ev.tok_valid && ev.tok == TOK_SETUP;
  assign is_out = ev.tok_valid && ev.tok == TOK_OUT;
  assign is_in = ev.tok_valid && ev.tok == TOK_IN;
  // Damaged packets are simply dropped: no flag, no interrupt
  assign rx_ok = ev.rx_done && !ev.rx_err;
  assign short_rx = ev.rx_len < MAX_PKT;
  assign short_tx = ev.tx_len < MAX_PKT;

  always_comb begin
    r_nxt = r_r;
    fire_irq = 1'b0;
    r_nxt.hs = '0;
    r_nxt.pready = 1'b0;
    // Software writes take effect on the access edge; hardware sets below override clears
    if (wr_csr) begin
      if (wb[`B_OUT_SERV]) begin
        r_nxt.out_rdy = 1'b0;
      end
      if (wb[`B_SETUP_END_SERV]) begin
        r_nxt.setup_end = 1'b0;
      end
      if (!wb[`B_STALL_SENT]) begin
        r_nxt.stall_sent = 1'b0;
      end
      if (wb[`B_SEND_STALL]) begin
        r_nxt.send_stall = 1'b1;
      end
      if (wb[`B_IN_RDY]) begin
        r_nxt.in_rdy = 1'b1;
      end
      if (wb[`B_LAST_DONE]) begin
        r_nxt.last_done = 1'b1;
      end
    end
    if (is_setup || is_out) begin
      // A token out of sequence ends the transfer early
      if (r_r.phase == PH_TX && !r_r.last_done) begin
        r_nxt.setup_end = 1'b1;
        fire_irq = 1'b1;
      end
      if (r_r.phase == PH_RX && is_setup && !r_r.last_done) begin
        r_nxt.setup_end = 1'b1;
        fire_irq = 1'b1;
      end
    end
    if (is_in && r_r.phase == PH_RX && !r_r.last_done) begin
      r_nxt.setup_end = 1'b1;
      fire_irq = 1'b1;
    end
    // Token and handshake handling
    if (ev.tok_valid) begin
      case (ev.tok)
        TOK_SETUP: begin
          r_nxt.phase = PH_IDLE;
          r_nxt.send_stall = 1'b0;
          r_nxt.last_done = 1'b0;
        end
        TOK_OUT: begin
          if (r_r.send_stall || (r_r.phase == PH_RX && r_r.last_done)) begin
            r_nxt.stall_pend = 1'b1;
          end else if (r_r.phase == PH_TX) begin
            r_nxt.phase = PH_STATUS_IN;
          end else if (r_r.phase == PH_IDLE) begin
            r_nxt.phase = PH_RX;
          end
        end
        TOK_IN: begin
          if (r_r.send_stall || (r_r.phase == PH_TX && r_r.last_done && !r_r.in_rdy)) begin
            r_nxt.stall_pend = 1'b1;
          end else if (!r_r.in_rdy) begin
            r_nxt.hs.hs_valid = 1'b1;
            r_nxt.hs.hs_nak = 1'b1;
            if (r_r.phase != PH_TX) begin
              r_nxt.phase = (r_r.phase == PH_RX) ? PH_IDLE : PH_TX;
            end
          end else if (r_r.phase != PH_TX) begin
            r_nxt.phase = PH_TX;
          end
        end
        default: begin
        end
      endcase
    end
    // Received data packet
    if (rx_ok) begin
      if (ev.rx_over || (r_r.phase == PH_STATUS_IN && ev.rx_data1 && ev.rx_len != 7'h00)) begin
        r_nxt.stall_pend = 1'b1;
      end else if (r_r.phase == PH_STATUS_IN) begin
        r_nxt.hs.hs_valid = 1'b1;
        r_nxt.hs.hs_ack = 1'b1;
        r_nxt.phase = PH_IDLE;
        r_nxt.last_done = 1'b0;
        fire_irq = 1'b1;
      end else if (r_r.phase == PH_IDLE && r_r.stall_pend == 1'b0 && ev.rx_len != `SETUP_LEN
                   && !r_r.out_rdy && r_r.send_stall == 1'b0 && r_nxt.phase == PH_IDLE) begin
        // Wrong-length SETUP: dropped without handshake
        r_nxt.hs = '0;
      end else if (!r_r.out_rdy) begin
        r_nxt.out_rdy = 1'b1;
        r_nxt.rx_cnt = ev.rx_len;
        r_nxt.hs.hs_valid = 1'b1;
        r_nxt.hs.hs_ack = 1'b1;
        fire_irq = 1'b1;
        if (r_r.in_rdy) begin
          r_nxt.in_rdy = 1'b0;
        end
        if (r_r.phase == PH_RX && short_rx) begin
          r_nxt.phase = PH_IDLE;
        end
      end else begin
        r_nxt.hs.hs_valid = 1'b1;
        r_nxt.hs.hs_nak = 1'b1;
      end
    end
    // Host acknowledged our IN data
    if (ev.tx_acked) begin
      r_nxt.in_rdy = 1'b0;
      fire_irq = 1'b1;
      if (short_tx) begin
        r_nxt.phase = PH_IDLE;
        r_nxt.last_done = 1'b0;
      end
    end
    // Issue pending STALL; flags follow on the same edge
    if (r_r.stall_pend) begin
      r_nxt.stall_pend = 1'b0;
      // STALL replaces any ACK or NAK chosen above, so the host never sees two handshakes
      r_nxt.hs = '0;
      r_nxt.hs.hs_valid = 1'b1;
      r_nxt.hs.hs_stall = 1'b1;
      r_nxt.stall_sent = 1'b1;
      r_nxt.send_stall = 1'b0;
      r_nxt.last_done = 1'b0;
      r_nxt.in_rdy = 1'b0;
      r_nxt.phase = PH_IDLE;
      fire_irq = 1'b1;
    end
    r_nxt.irq = fire_irq;
    // APB: no wait state, read data captured in setup phase
    if (rd_acc) begin
      r_nxt.pready = 1'b1;
      if (paddr == `EP0_CSR_ADDR) begin
        r_nxt.prdata = {24'h00_0000, 2'b00, r_r.send_stall, r_r.setup_end, r_r.last_done,
                        r_r.stall_sent, r_r.in_rdy, r_r.out_rdy};
      end else if (paddr == `EP0_CNT_ADDR) begin
        r_nxt.prdata = {24'h00_0000, 1'b0, r_r.rx_cnt};
      end else begin
        r_nxt.prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r_r <= '{phase: PH_IDLE, hs: '0, prdata: 32'h0000_0000, default: '0};
      pslverr_r <= 1'b0;
    end else begin
      r_r <= r_nxt;
      pslverr_r <= rd_acc && (paddr != `EP0_CSR_ADDR) && (paddr != `EP0_CNT_ADDR);
    end
  end

  assign prdata = r_r.prdata;
  assign pready = r_r.pready;
  assign pslverr = pslverr_r;
  assign hs = r_r.hs;
  assign ep0_irq = r_r.irq;

  sequence s_stall_req;
    r_r.stall_pend;
  endsequence
  sequence s_stall_out;
    hs.hs_stall && r_r.stall_sent && ep0_irq;
  endsequence

  property p_stall_flow;
    @(posedge sys_clk) disable iff (sys_rst) s_stall_req |=> s_stall_out;
  endproperty
  a_stall_flow: assert property (p_stall_flow) else $error("stall not issued with flag");

  property p_stall_clears_send;
    @(posedge sys_clk) disable iff (sys_rst) hs.hs_stall |-> !r_r.send_stall;
  endproperty
  a_stall_clears_send: assert property (p_stall_clears_send) else $error("send_stall kept");

  property p_nak_no_pkt;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_in && !r_r.in_rdy && !r_r.send_stall && !(r_r.phase == PH_TX && r_r.last_done)) |=> hs.hs_nak;
  endproperty
  a_nak_no_pkt: assert property (p_nak_no_pkt) else $error("no NAK on empty IN");

  property p_err_quiet;
    @(posedge sys_clk) disable iff (sys_rst)
      (ev.rx_err && !ev.tx_acked && !ev.tok_valid && !r_r.stall_pend && !wr_csr) |=> !ep0_irq;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("interrupt on bad packet");

  property p_out_rdy_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      (r_r.out_rdy && !(wr_csr && wb[`B_OUT_SERV])) |=> r_r.out_rdy;
  endproperty
  a_out_rdy_hold: assert property (p_out_rdy_hold) else $error("out_pkt_ready lost");

  property p_ack_irq;
    @(posedge sys_clk) disable iff (sys_rst) ev.tx_acked |=> (ep0_irq && !r_r.in_rdy);
  endproperty
  a_ack_irq: assert property (p_ack_irq) else $error("IN sent without interrupt");

  property p_cnt_top;
    @(posedge sys_clk) disable iff (sys_rst) pready && paddr == `EP0_CNT_ADDR |-> prdata[31:7] == '0;
  endproperty
  a_cnt_top: assert property (p_cnt_top) else $error("count high bits set");

  property p_setup_end_flag_clear;
    @(posedge sys_clk) disable iff (sys_rst)
      (wr_csr && wb[`B_SETUP_END_SERV] && !ev.tok_valid) |=> !r_r.setup_end;
  endproperty
  a_setup_end_flag_clear: assert property (p_setup_end_flag_clear) else $error("setup end not cleared");

  property p_tx_mode;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_in && r_r.phase == PH_IDLE && !r_r.send_stall && !r_r.stall_pend && !ev.tx_acked && !rx_ok) |=>
      r_r.phase == PH_TX;
  endproperty
  a_tx_mode: assert property (p_tx_mode) else $error("no transmit mode");

  sequence s_apb_setup;
    psel && !penable;
  endsequence
  sequence s_apb_answer;
    pready;
  endsequence

  // Access phase is exactly one cycle long
  property p_apb_one_wait;
    @(posedge sys_clk) disable iff (sys_rst) s_apb_setup |=> s_apb_answer;
  endproperty
  a_apb_one_wait: assert property (p_apb_one_wait) else $error("access phase not answered");

  property p_apb_pulse;
    @(posedge sys_clk) disable iff (sys_rst) pready |=> !pready;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("ready held too long");

  property p_oversize_stall;
    @(posedge sys_clk) disable iff (sys_rst)
      (rx_ok && ev.rx_over && !r_r.stall_pend) |=> s_stall_req ##1 s_stall_out;
  endproperty
  a_oversize_stall: assert property (p_oversize_stall) else $error("oversize packet not stalled");

  property p_out_sets_rdy;
    @(posedge sys_clk) disable iff (sys_rst)
      (rx_ok && !ev.rx_over && r_r.phase == PH_RX && !r_r.out_rdy && !r_r.stall_pend) |=>
      (r_r.out_rdy && ep0_irq && hs.hs_ack);
  endproperty
  a_out_sets_rdy: assert property (p_out_sets_rdy) else $error("OUT packet not flagged");

  property p_setup_reject;
    @(posedge sys_clk) disable iff (sys_rst)
      (rx_ok && !ev.rx_over && r_r.phase == PH_IDLE && ev.rx_len != `SETUP_LEN && !r_r.out_rdy
       && !r_r.send_stall && !r_r.stall_pend && !ev.tok_valid && !ev.tx_acked) |=>
      (!hs.hs_valid && !r_r.out_rdy && !ep0_irq);
  endproperty
  a_setup_reject: assert property (p_setup_reject) else $error("bad SETUP length accepted");

  property p_setup_end_flag_tx;
    @(posedge sys_clk) disable iff (sys_rst)
      ((is_setup || is_out) && r_r.phase == PH_TX && !r_r.last_done) |=> (r_r.setup_end && ep0_irq);
  endproperty
  a_setup_end_flag_tx: assert property (p_setup_end_flag_tx) else $error("early end in transmit mode missed");

  property p_setup_end_flag_rx;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_in && r_r.phase == PH_RX && !r_r.last_done) |=> (r_r.setup_end && ep0_irq);
  endproperty
  a_setup_end_flag_rx: assert property (p_setup_end_flag_rx) else $error("early end in receive mode missed");

  property p_rx_mode;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_out && r_r.phase == PH_IDLE && !r_r.send_stall && !r_r.stall_pend && !rx_ok && !ev.tx_acked) |=>
      r_r.phase == PH_RX;
  endproperty
  a_rx_mode: assert property (p_rx_mode) else $error("no receive mode");

  property p_in_overwrite;
    @(posedge sys_clk) disable iff (sys_rst)
      (rx_ok && !ev.rx_over && r_r.in_rdy && !r_r.out_rdy && r_r.phase == PH_RX) |=>
      (!r_r.in_rdy && ep0_irq);
  endproperty
  a_in_overwrite: assert property (p_in_overwrite) else $error("IN packet kept after overwrite");

  property p_hs_onehot;
    @(posedge sys_clk) disable iff (sys_rst) hs.hs_valid |-> $onehot({hs.hs_ack, hs.hs_nak, hs.hs_stall});
  endproperty
  a_hs_onehot: assert property (p_hs_onehot) else $error("more than one handshake");

  property p_status_done;
    @(posedge sys_clk) disable iff (sys_rst)
      (rx_ok && r_r.phase == PH_STATUS_IN && !ev.rx_over && !(ev.rx_data1 && ev.rx_len != 7'h00)
       && !r_r.stall_pend) |=> (hs.hs_ack && ep0_irq && r_r.phase == PH_IDLE);
  endproperty
  a_status_done: assert property (p_status_done) else $error("status stage not completed");

endmodule

// file: ep0_defines.svh
// Register offsets, field positions, reset values and packet-length constants for the endpoint-zero control block
`ifndef EP0_DEFINES_SVH
`define EP0_DEFINES_SVH
// Printed offsets are not multiples of four: they are indices, byte address is index*4
`define EP0_CSR_IDX 8'h11
`define EP0_CNT_IDX 8'h16
`define EP0_CSR_ADDR 12'h044
`define EP0_CNT_ADDR 12'h058
`define EP0_CSR_RESET 8'h00
`define EP0_CNT_RESET 8'h00
`define B_OUT_RDY 0
`define B_IN_RDY 1
`define B_STALL_SENT 2
`define B_LAST_DONE 3
`define B_SETUP_END 4
`define B_SEND_STALL 5
`define B_OUT_SERV 6
`define B_SETUP_END_SERV 7
`define EP0_MAX_PKT 7'h40
`define SETUP_LEN 7'h08
`endif

// file: ep0_pkg.sv
// Types shared by the endpoint-zero control block
package ep0_pkg;
  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_TX = 4'b0010,
    PH_RX = 4'b0100,
    PH_STATUS_IN = 4'b1000
  } phase_e;

  typedef enum logic [2:0] {
    TOK_NONE = 3'h0,
    TOK_SETUP = 3'h1,
    TOK_OUT = 3'h2,
    TOK_IN = 3'h3
  } token_e;

  // One received or transmitted transaction as reported by the link engine
  typedef struct packed {
    logic tok_valid;
    token_e tok;
    logic rx_done;
    logic rx_err;
    logic rx_data1;
    logic [6:0] rx_len;
    logic rx_over;
    logic tx_acked;
    logic [6:0] tx_len;
  } link_ev_s;

  typedef struct packed {
    logic hs_valid;
    logic hs_ack;
    logic hs_nak;
    logic hs_stall;
  } hs_s;

  typedef struct packed {
    phase_e phase;
    logic out_rdy;
    logic in_rdy;
    logic stall_sent;
    logic last_done;
    logic setup_end;
    logic send_stall;
    logic [6:0] rx_cnt;
    logic stall_pend;
    hs_s hs;
    logic irq;
    logic pready;
    logic [31:0] prdata;
  } state_s;
endpackage

// file: usb_host_model.sv
// Host-side model that issues endpoint-zero tokens, data packets and acknowledges
module usb_host_model
  import ep0_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Link events toward the device
  output link_ev_s ev
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ev = '0;
  end
  // One event per call; events go out in the caller's order, with no check that a data event follows its token
  // Idle cycles carry no valid or done strobe, so the other fields mean nothing
  task automatic pulse(input link_ev_s e);
    @(posedge sys_clk);
    ev <= e;
    @(posedge sys_clk);
    ev <= '0;
  endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the endpoint-zero control block
`include "ep0_defines.svh"
module tb_top
  import ep0_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] want;
    logic err;
  } row_s;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  link_ev_s ev;
  hs_s hs;
  logic ep0_irq;
  int n_fail = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic er;
  logic [4:0] ob;
  link_ev_s evx;
  // Reset values, read-only count, unmapped place, self-clearing command bits
  row_s rows [7] = '{
    '{1'b0, `EP0_CSR_ADDR, '0, '0, 1'b0},
    '{1'b0, `EP0_CNT_ADDR, '0, '0, 1'b0},
    '{1'b1, `EP0_CNT_ADDR, 32'h0000_00ff, '0, 1'b0},
    '{1'b0, `EP0_CNT_ADDR, '0, '0, 1'b0},
    '{1'b0, 12'h000, '0, '0, 1'b1},
    '{1'b1, `EP0_CSR_ADDR, 32'h0000_00c0, '0, 1'b0},
    '{1'b0, `EP0_CSR_ADDR, '0, '0, 1'b0}
  };

  usb_endpoint0_control uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ev(ev), .hs(hs), .ep0_irq(ep0_irq));
  usb_host_model host (.sys_clk(sys_clk), .ev(ev));

  always #25 sys_clk = ~sys_clk;

  task automatic results();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      results();
    end
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic reg_chk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, '0, rd, er);
    chk(rd, x);
  endtask

  // Collects {irq, handshake} over a window long enough for the two-edge STALL path
  task automatic ev_chk(input link_ev_s e, input logic [4:0] x);
    ob = '0;
    host.pulse(e);
    repeat (4) begin
      #1;
      ob = ob | {ep0_irq, hs};
      @(posedge sys_clk);
    end
    chk({27'h000_0000, ob}, {27'h000_0000, x});
  endtask

  function automatic link_ev_s tk(input token_e t);
    link_ev_s e;
    e = '0;
    e.tok_valid = 1'b1;
    e.tok = t;
    return e;
  endfunction

  function automatic link_ev_s rx(input logic [6:0] n, input logic bad);
    link_ev_s e;
    e = '0;
    e.rx_done = 1'b1;
    e.rx_len = n;
    e.rx_err = bad;
    return e;
  endfunction

  function automatic link_ev_s tx(input logic [6:0] n);
    link_ev_s e;
    e = '0;
    e.tx_acked = 1'b1;
    e.tx_len = n;
    return e;
  endfunction

  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata, rd, er);
      chk({31'h0000_0000, er}, {31'h0000_0000, rows[i].err});
      if (!rows[i].wr) chk(rd, rows[i].want);
    end
    ev_chk(tk(TOK_SETUP), 5'h00);
    ev_chk(rx(7'h05, 1'b0), 5'h00);
    ev_chk(tk(TOK_SETUP), 5'h00);
    ev_chk(rx(`SETUP_LEN, 1'b1), 5'h00);
    ev_chk(tk(TOK_SETUP), 5'h00);
    ev_chk(rx(`SETUP_LEN, 1'b0), 5'h1c);
    reg_chk(`EP0_CNT_ADDR, 32'h0000_0008);
    reg_chk(`EP0_CSR_ADDR, 32'h0000_0001);
    reg_wr(`EP0_CSR_ADDR, 32'h0000_0040);
    reg_chk(`EP0_CSR_ADDR, 32'h0000_0000);
    // Forced STALL must drop send_stall and leave stall_sent up
    reg_wr(`EP0_CSR_ADDR, 32'h0000_0020);
    ev_chk(tk(TOK_IN), 5'h19);
    reg_chk(`EP0_CSR_ADDR, 32'h0000_0004);
    reg_wr(`EP0_CSR_ADDR, 32'h0000_0000);
    reg_chk(`EP0_CSR_ADDR, 32'h0000_0000);
    ev_chk(tk(TOK_IN), 5'h0a);
    reg_wr(`EP0_CSR_ADDR, 32'h0000_0002);
    ev_chk(tk(TOK_IN), 5'h00);
    // A full-size packet keeps transmit mode, so the OUT token ends the transfer early
    ev_chk(tx(`EP0_MAX_PKT), 5'h10);
    reg_chk(`EP0_CSR_ADDR, 32'h0000_0000);
    ev_chk(tk(TOK_OUT), 5'h10);
    reg_chk(`EP0_CSR_ADDR, 32'h0000_0010);
    reg_wr(`EP0_CSR_ADDR, 32'h0000_0080);
    reg_chk(`EP0_CSR_ADDR, 32'h0000_0000);
    // Status stage with a non-empty DATA1 is a protocol error
    evx = rx(7'h04, 1'b0);
    evx.rx_data1 = 1'b1;
    ev_chk(evx, 5'h19);
    reg_chk(`EP0_CSR_ADDR, 32'h0000_0004);
    reg_wr(`EP0_CSR_ADDR, 32'h0000_0000);
    // Receive mode: full-size OUT keeps it, then an IN ends the transfer early
    ev_chk(tk(TOK_OUT), 5'h00);
    ev_chk(rx(`EP0_MAX_PKT, 1'b0), 5'h1c);
    reg_wr(`EP0_CSR_ADDR, 32'h0000_0040);
    ev_chk(tk(TOK_IN), 5'h1a);
    reg_chk(`EP0_CSR_ADDR, 32'h0000_0010);
    reg_wr(`EP0_CSR_ADDR, 32'h0000_0080);
    evx = rx(`EP0_MAX_PKT, 1'b0);
    evx.rx_over = 1'b1;
    ev_chk(evx, 5'h19);
    reg_chk(`EP0_CSR_ADDR, 32'h0000_0004);
    results();
  end
endmodule
